//--- hw/vrm_pkg.sv
// Shared constants and types of the video refresh memory card.
// Assumes a 250 MHz system clock and a free shift clock from the scanner.
package vrm_pkg;
   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int WORD_W    = 16;
   localparam int WADDR_W   = 14;
   localparam int BSEL_W    = 4;
   localparam int ADDR_W    = 18;
   localparam int ROW_W     = 8;
   localparam int EXT_ROWS  = 64;
   localparam int EXT_ROW_W = 6;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_NS     = 4;
   localparam int RETAIN_NS  = 2000000;
   localparam int RETAIN_CYC = RETAIN_NS / CLK_NS;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [3:0]  REG_CTRL     = 4'h0;
   localparam logic [3:0]  REG_STATUS   = 4'h4;
   localparam logic [3:0]  REG_REFCNT   = 4'h8;
   localparam int          CTRL_EXT_BIT = 0;
   localparam int          ST_BUSY_BIT  = 0;
   localparam int          ST_LATE_BIT  = 1;
   localparam int          ST_AUTO_LSB  = 8;
   localparam int          ST_EXT_LSB   = 16;
   localparam logic        CTRL_RESET   = 1'b0;
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_DONE} vrm_state_type;
endpackage

//--- hw/vrm_word_mem.sv
// Word store of the card with bit-granular write mask.
// Assumes one access per cycle; read data come out of a register.
`timescale 1ns/1ps
`default_nettype none
module vrm_word_mem #(
   parameter int WIDTH = 16,
   parameter int AW    = 14
) (
   input  wire logic             clk_sys,
   input  wire logic [AW-1:0]    addr,
   input  wire logic             re,
   input  wire logic             we,
   input  wire logic [WIDTH-1:0] wmask,
   input  wire logic [WIDTH-1:0] wdata,
   output var  logic [WIDTH-1:0] rdata
);
   if (WIDTH < 1 || AW < 1) begin : g_chk
      $error("vrm_word_mem: bad geometry");
   end

   logic [WIDTH-1:0] store [2**AW];

   always_ff @(posedge clk_sys) begin
      if (re) begin
         rdata <= store[addr];
      end
      if (we) begin
         for (int i = 0; i < WIDTH; i++) begin
            if (wmask[i]) begin
               store[addr][i] <= wdata[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- hw/vrm_shift_out.sv
// Parallel-to-serial output register on the scanner's shift clock.
// Assumes the word is held stable in the system domain across a toggle.
`timescale 1ns/1ps
`default_nettype none
module vrm_shift_out
   import vrm_pkg::*;
(
   input  wire logic              clk_shift,
   input  wire logic              reset_n,
   input  wire logic [WORD_W-1:0] hold_word,
   input  wire logic              hold_tgl,
   input  wire logic              shift_load,
   output var  logic              serial_out
);
   logic              rst_s1;
   logic              rst_n_link;
   logic              tgl_s1;
   logic              tgl_s2;
   logic              tgl_prev;
   logic [WORD_W-1:0] link_word;
   logic [WORD_W-1:0] sreg;

   // Reset and toggle both cross by two flops
   always_ff @(posedge clk_shift) begin
      rst_s1     <= reset_n;
      rst_n_link <= rst_s1;
      tgl_s1     <= hold_tgl;
      tgl_s2     <= tgl_s1;
   end

   // Word is copied only after its toggle settled, so it is stable
   always_ff @(posedge clk_shift) begin
      if (!rst_n_link) begin
         tgl_prev  <= 1'b0;
         link_word <= '0;
      end else begin
         tgl_prev <= tgl_s2;
         if (tgl_s2 != tgl_prev) begin
            link_word <= hold_word;
         end
      end
   end

   // MSB first; load wins over shift
   always_ff @(posedge clk_shift) begin
      if (!rst_n_link) begin
         sreg       <= '0;
         serial_out <= 1'b0;
      end else if (shift_load) begin
         serial_out <= link_word[WORD_W-1];
         sreg       <= {link_word[WORD_W-2:0], 1'b0};
      end else begin
         serial_out <= sreg[WORD_W-1];
         sreg       <= {sreg[WORD_W-2:0], 1'b0};
      end
   end

   logic load_msb;
   assign load_msb = link_word[WORD_W-1];

   load_first_a: assert property (
      @(posedge clk_shift) disable iff (!rst_n_link)
      shift_load |=> serial_out == $past(load_msb))
      else $error("serial load did not present the MSB");
endmodule
`default_nettype wire

//--- hw/vrm_card.sv
// Control logic of the video refresh memory card.
// Assumes scanner pins are asynchronous to clk_sys and held per cycle,
// and an Avalon-MM master for the control and status registers.
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module vrm_card
   import vrm_pkg::*;
#(
   parameter int RETAIN_CYCLES = RETAIN_CYC
) (
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   input  wire logic              clk_shift,
   input  wire logic [3:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output var  logic [31:0]       avs_readdata,
   output var  logic              avs_waitrequest,
   input  wire logic              card_sel,
   input  wire logic              cycle_req,
   input  wire logic              write_en,
   input  wire logic              word_mode,
   input  wire logic              clear_en,
   input  wire logic              clear_value,
   input  wire logic              split_en,
   input  wire logic              refresh_req,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [WORD_W-1:0] data_in,
   output var  logic [WORD_W-1:0] data_out,
   output var  logic              data_oe,
   input  wire logic              bit_in,
   output var  logic              bit_out,
   output var  logic              bit_oe,
   input  wire logic              shift_load,
   output var  logic              serial_out,
   output var  logic              busy,
   output var  logic              data_ready
);
   if (RETAIN_CYCLES < 2) begin : g_chk
      $error("vrm_card: RETAIN_CYCLES too small");
   end

   localparam int PIN_W  = 9 + WORD_W + ADDR_W;
   localparam int LATE_W = $clog2(RETAIN_CYCLES + 1);

   function automatic logic [WORD_W-1:0] vrm_bit_mask(
      input logic [BSEL_W-1:0] sel);
      logic [WORD_W-1:0] m;
      m      = '0;
      m[sel] = 1'b1;
      return m;
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [PIN_W-1:0]  pin_s1;
   logic [PIN_W-1:0]  pin_s2;
   logic              p_sel;
   logic              p_req;
   logic              p_we;
   logic              p_word;
   logic              p_clr;
   logic              p_clrval;
   logic              p_split;
   logic              p_ref;
   logic              p_bit;
   logic [WORD_W-1:0] p_data;
   logic [ADDR_W-1:0] p_addr;
   logic              req_prev;
   logic              req_rise;

   // Address and data ride with the request, so a cycle sees one snapshot
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         pin_s1 <= {card_sel, cycle_req, write_en, word_mode, clear_en,
                    clear_value, split_en, refresh_req, bit_in, data_in,
                    addr};
         pin_s2 <= pin_s1;
      end
   end

   assign {p_sel, p_req, p_we, p_word, p_clr, p_clrval, p_split, p_ref,
           p_bit, p_data, p_addr} = pin_s2;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         req_prev <= 1'b0;
      end else begin
         req_prev <= p_req;
      end
   end

   assign req_rise = p_req && !req_prev;

   // ---------------------------------------------------------------
   // Cycle sequencer
   // ---------------------------------------------------------------
   vrm_state_type      state;
   vrm_state_type      next_state;
   logic               op_word;
   logic               op_split;
   logic               op_we;
   logic [BSEL_W-1:0]  op_bsel;
   logic [WADDR_W-1:0] op_waddr;
   logic               accept;
   logic               sel_word;
   logic [BSEL_W-1:0]  sel_bsel;
   logic [WADDR_W-1:0] mem_addr;
   logic               mem_re;
   logic               mem_we;
   logic [WORD_W-1:0]  mem_mask;
   logic [WORD_W-1:0]  mem_wdata;
   logic [WORD_W-1:0]  mem_rdata;
   logic               ref_step;
   logic               ext_en;

   assign accept   = (state == ST_IDLE) && req_rise && p_sel;
   assign sel_word = (state == ST_IDLE) ? p_word : op_word;
   assign sel_bsel = (state == ST_IDLE) ? p_addr[BSEL_W-1:0] : op_bsel;
   // Word address over bit select: 16K x 16 or 256K x 1
   assign mem_addr = (state == ST_IDLE) ?
                     p_addr[ADDR_W-1:BSEL_W] : op_waddr;

   always_comb begin
      next_state = state;
      mem_re     = 1'b0;
      mem_we     = 1'b0;
      ref_step   = 1'b0;
      mem_mask   = sel_word ? '1 : vrm_bit_mask(sel_bsel);
      mem_wdata  = sel_word ? p_data : {WORD_W{p_bit}};
      unique case (state)
         ST_IDLE: begin
            if (accept && p_ref) begin
               ref_step   = ext_en;
               next_state = ST_DONE;
            end else if (accept && p_clr) begin
               mem_we     = 1'b1;
               mem_mask   = '1;
               mem_wdata  = {WORD_W{p_clrval}};
               next_state = ST_DONE;
            end else if (accept && p_we && !p_split) begin
               mem_we     = 1'b1;
               next_state = ST_DONE;
            end else if (accept) begin
               mem_re     = 1'b1;
               next_state = ST_READ;
            end
         end
         ST_READ: begin
            mem_we     = op_split && op_we;
            next_state = ST_DONE;
         end
         ST_DONE: begin
            if (!p_req) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         op_word  <= 1'b0;
         op_split <= 1'b0;
         op_we    <= 1'b0;
         op_bsel  <= '0;
         op_waddr <= '0;
      end else if (accept) begin
         op_word  <= p_word;
         op_split <= p_split;
         op_we    <= p_we;
         op_bsel  <= p_addr[BSEL_W-1:0];
         op_waddr <= p_addr[ADDR_W-1:BSEL_W];
      end
   end

   vrm_word_mem #(
      .WIDTH (WORD_W),
      .AW    (WADDR_W)
   ) u_mem (
      .clk_sys (clk_sys),
      .addr    (mem_addr),
      .re      (mem_re),
      .we      (mem_we),
      .wmask   (mem_mask),
      .wdata   (mem_wdata),
      .rdata   (mem_rdata)
   );

   // ---------------------------------------------------------------
   // Pin answers and serial hand-over
   // ---------------------------------------------------------------
   logic [WORD_W-1:0] hold_word;
   logic              hold_tgl;
   logic              bit_pick;
   logic [ROW_W-1:0]  op_row;
   logic [ROW_W-1:0]  auto_row;

   assign bit_pick = mem_rdata[op_bsel];
   assign op_row   = op_waddr[ROW_W-1:0];

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         data_out   <= '0;
         data_oe    <= 1'b0;
         bit_out    <= 1'b0;
         bit_oe     <= 1'b0;
         busy       <= 1'b0;
         data_ready <= 1'b0;
      end else begin
         busy       <= (next_state == ST_READ);
         data_ready <= (next_state == ST_DONE);
         if (state == ST_READ && op_word) begin
            data_out <= mem_rdata;
            data_oe  <= 1'b1;
         end else if (state == ST_READ) begin
            bit_out <= bit_pick;
            bit_oe  <= 1'b1;
         end else if (next_state == ST_IDLE) begin
            data_oe <= 1'b0;
            bit_oe  <= 1'b0;
         end
      end
   end

   // Bit reads leave the serial word alone, so scan output continues
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         hold_word <= '0;
         hold_tgl  <= 1'b0;
         auto_row  <= '0;
      end else if (state == ST_READ && op_word) begin
         hold_word <= mem_rdata;
         hold_tgl  <= !hold_tgl;
         auto_row  <= op_row;
      end
   end

   vrm_shift_out u_shift (
      .clk_shift  (clk_shift),
      .reset_n    (reset_n),
      .hold_word  (hold_word),
      .hold_tgl   (hold_tgl),
      .shift_load (shift_load),
      .serial_out (serial_out)
   );

   // ---------------------------------------------------------------
   // External refresh and retention watchdog
   // ---------------------------------------------------------------
   logic [EXT_ROW_W-1:0] ext_row;
   logic [15:0]          ref_count;
   logic [LATE_W-1:0]    late_cnt;
   logic                 late;
   logic                 late_hit;
   logic                 late_clr;
   logic                 pass_done;

   assign pass_done = ref_step &&
                      (ext_row == EXT_ROW_W'(EXT_ROWS - 1));
   assign late_hit  = ext_en && !pass_done &&
                      (late_cnt == LATE_W'(RETAIN_CYCLES - 1));

   // One row of every RAM per step; 64 steps cover the array
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ext_row   <= '0;
         ref_count <= '0;
      end else if (ref_step) begin
         ext_row   <= ext_row + 1'b1;
         ref_count <= ref_count + 1'b1;
      end
   end

   // Flags a pass of 64 steps that did not finish within retention
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         late_cnt <= '0;
      end else if (!ext_en || pass_done) begin
         late_cnt <= '0;
      end else if (!late_hit) begin
         late_cnt <= late_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         late <= 1'b0;
      end else if (late_hit) begin
         late <= 1'b1;
      end else if (late_clr) begin
         late <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Avalon-MM slave
   // ---------------------------------------------------------------
   logic        bus_req;
   logic        wr_take;
   logic [31:0] rd_mux;

   assign bus_req  = avs_read || avs_write;
   assign wr_take  = avs_write && !avs_waitrequest;
   assign late_clr = wr_take && (avs_address == REG_STATUS) &&
                     avs_writedata[ST_LATE_BIT];

   always_comb begin
      rd_mux = '0;
      unique case (avs_address)
         REG_CTRL: begin
            rd_mux[CTRL_EXT_BIT] = ext_en;
         end
         REG_STATUS: begin
            rd_mux[ST_BUSY_BIT]                     = busy;
            rd_mux[ST_LATE_BIT]                     = late;
            rd_mux[ST_AUTO_LSB +: ROW_W]            = auto_row;
            rd_mux[ST_EXT_LSB +: EXT_ROW_W]         = ext_row;
         end
         REG_REFCNT: begin
            rd_mux[15:0] = ref_count;
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   // One wait cycle per access; data stand while waitrequest is low
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= '0;
      end else begin
         avs_waitrequest <= !(bus_req && avs_waitrequest);
         if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ext_en <= CTRL_RESET;
      end else if (wr_take && avs_address == REG_CTRL) begin
         ext_en <= avs_writedata[CTRL_EXT_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence s_word_read;
      state == ST_READ && op_word;
   endsequence

   sequence s_last_row;
      ref_step && ext_row == EXT_ROW_W'(EXT_ROWS - 1);
   endsequence

   word_drive_a: assert property (
      s_word_read |=> data_oe && data_out == $past(mem_rdata))
      else $error("word read not driven on data lines");

   serial_hand_a: assert property (
      s_word_read |=> hold_tgl != $past(hold_tgl) ##1 $stable(hold_word))
      else $error("word read not handed to serial path");

   bit_pick_a: assert property (
      (state == ST_READ && !op_word) |=>
         bit_oe && bit_out == $past(bit_pick) && !data_oe)
      else $error("bit read drove wrong line or bit");

   bit_serial_a: assert property (
      (state == ST_READ && !op_word) |=> $stable(hold_tgl))
      else $error("bit read disturbed serial readout");

   bit_write_a: assert property (
      (mem_we && !sel_word && !(accept && p_clr)) |->
         $onehot(mem_mask))
      else $error("bit write touched more than one bit");

   clear_fill_a: assert property (
      (accept && !p_ref && p_clr) |->
         mem_we && mem_mask == '1 &&
         mem_wdata == {WORD_W{p_clrval}} ##1 state == ST_DONE)
      else $error("clear-set did not fill the word");

   split_cycle_a: assert property (
      (accept && !p_ref && !p_clr && p_we && p_split) |=>
         mem_we && mem_addr == $past(mem_addr) ##1 state == ST_DONE)
      else $error("split cycle did not write back");

   auto_row_a: assert property (
      s_word_read |=> auto_row == $past(op_row))
      else $error("scan row not recorded");

   ext_wrap_a: assert property (
      s_last_row |=> ext_row == '0 && late_cnt == '0)
      else $error("external refresh pass did not wrap");

   select_gate_a: assert property (
      (state == ST_IDLE && !p_sel) |=> state == ST_IDLE)
      else $error("unselected card started a cycle");

   bus_answer_a: assert property (
      (bus_req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus access not answered in one cycle");
endmodule
`default_nettype wire

//--- verif/vrm_scan_model.sv
// Scanner model: free shift clock, load strobe, serial capture.
// Assumes go is raised only after a word read has completed.
`timescale 1ns/1ps
`default_nettype none
module vrm_scan_model (
   input  wire logic        go,
   input  wire logic        serial_out,
   output var  logic        clk_shift,
   output var  logic        shift_load,
   output var  logic        done,
   output var  logic [15:0] word
);
   initial begin
      clk_shift = 1'b0;
      #7;
      forever #40 clk_shift = ~clk_shift;
   end
   // Gap before load lets the word cross into the link domain
   initial begin
      shift_load = 1'b0;
      done = 1'b0;
      word = 16'h0000;
      forever begin
         @(posedge go);
         done = 1'b0;
         repeat (4) @(posedge clk_shift);
         shift_load <= 1'b1;
         @(posedge clk_shift);
         shift_load <= 1'b0;
         repeat (16) begin
            @(negedge clk_shift);
            word = {word[14:0], serial_out};
         end
         done = 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench of the video refresh memory card.
// Assumes the scanner model supplies shift clock and load.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g,e) begin n_compared++; if ((g)!==(e)) begin n_fail++; \
$display("mismatch t=%0t got %h exp %h",$time,g,e); end end
module testbench
   import vrm_pkg::*;
;
   logic clk_sys, reset_n, avs_read, avs_write, card_sel, cycle_req;
   logic write_en, word_mode, clear_en, clear_value, split_en;
   logic refresh_req, bit_in, go, avs_waitrequest, data_oe, bit_out;
   logic bit_oe, serial_out, busy, data_ready, clk_shift, shift_load;
   logic done, ok, gbit;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, r;
   logic [17:0] addr;
   logic [15:0] data_in, data_out, word, got;
   int          n_fail, n_compared;
   vrm_card #(.RETAIN_CYCLES(200)) vrm_card_inst (.clk_sys, .reset_n,
      .clk_shift, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .card_sel, .cycle_req, .write_en,
      .word_mode, .clear_en, .clear_value, .split_en, .refresh_req, .addr,
      .data_in, .data_out, .data_oe, .bit_in, .bit_out, .bit_oe,
      .shift_load, .serial_out, .busy, .data_ready);
   vrm_scan_model vrm_scan_model_inst (.go, .serial_out, .clk_shift,
      .shift_load, .done, .word);
   always #2 clk_sys = ~clk_sys;
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Request held until waitrequest is sampled low
   task automatic av(input logic w, input logic [3:0] ad,
                     input logic [31:0] wd);
      int i;
      avs_address <= ad;
      avs_writedata <= wd;
      avs_read <= !w;
      avs_write <= w;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys);
         if (avs_waitrequest === 1'b0) break;
      end
      r = avs_readdata;
      if (i == 50) begin
         n_fail++;
         report_and_stop();
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Mode bits: sel, write, word, clear, value, split, refresh
   task automatic cyc(input logic [6:0] m, input logic [17:0] ad,
                      input logic [15:0] dd, input logic b);
      int i;
      logic rd;
      logic sb;
      {card_sel, write_en, word_mode, clear_en, clear_value, split_en,
       refresh_req} <= m;
      addr <= ad;
      data_in <= dd;
      bit_in <= b;
      // Only selected reads and split cycles fetch the word and drive a data or bit line
      rd = m[6] & ~m[3] & ~m[0] & (~m[5] | m[1]);
      sb = 1'b0;
      tick(4);
      cycle_req <= 1'b1;
      ok = 1'b0;
      for (i = 0; i < 20 && !ok; i++) begin
         @(posedge clk_sys);
         ok = (data_ready === 1'b1);
         sb = sb | (busy === 1'b1);
      end
      got = data_out;
      gbit = bit_out;
      `CHK(ok, m[6])
      `CHK(sb, rd)
      `CHK({data_oe, bit_oe}, {rd & m[4], rd & ~m[4]})
      cycle_req <= 1'b0;
      for (i = 0; i < 20 && data_ready !== 1'b0; i++) @(posedge clk_sys);
      if (i == 20) begin
         n_fail++;
         report_and_stop();
      end
      tick(2);
   endtask
   task automatic t_word;
      cyc(7'h70, 18'h00050, 16'h0123, 1'b0);
      cyc(7'h50, 18'h00050, 16'h0000, 1'b0);
      `CHK(got, 16'h0123)
      cyc(7'h30, 18'h00050, 16'hFFFF, 1'b0);
      `CHK(ok, 1'b0)
      cyc(7'h50, 18'h00050, 16'h0000, 1'b0);
      `CHK(got, 16'h0123)
      $display("test word done");
   endtask
   task automatic t_bit;
      cyc(7'h60, 18'h0005F, 16'h0000, 1'b1);
      cyc(7'h40, 18'h0005F, 16'h0000, 1'b0);
      `CHK(gbit, 1'b1)
      cyc(7'h40, 18'h00052, 16'hFFFF, 1'b1);
      `CHK(gbit, 1'b0)
      cyc(7'h50, 18'h00050, 16'h0000, 1'b0);
      `CHK(got, 16'h8123)
      $display("test bit done");
   endtask
   task automatic t_clear_split;
      cyc(7'h4C, 18'h00060, 16'h0000, 1'b0);
      cyc(7'h50, 18'h00060, 16'h0000, 1'b0);
      `CHK(got, 16'hFFFF)
      cyc(7'h48, 18'h00060, 16'hFFFF, 1'b1);
      cyc(7'h50, 18'h00060, 16'h0000, 1'b0);
      `CHK(got, 16'h0000)
      cyc(7'h72, 18'h00070, 16'hA5C3, 1'b0);
      cyc(7'h50, 18'h00070, 16'h0000, 1'b0);
      `CHK(got, 16'hA5C3)
      $display("test clear and split done");
   endtask
   task automatic t_serial;
      int i;
      cyc(7'h50, 18'h00050, 16'h0000, 1'b0);
      av(1'b0, REG_STATUS, 32'h0);
      `CHK(r[15:8], 8'h05)
      go <= 1'b1;
      tick(2);
      go <= 1'b0;
      // Bit read while the scanner still waits to load the word
      cyc(7'h40, 18'h0005F, 16'h0000, 1'b0);
      `CHK(gbit, 1'b1)
      for (i = 0; i < 3000 && done !== 1'b1; i++) @(posedge clk_sys);
      `CHK(done, 1'b1)
      if (done !== 1'b1) report_and_stop();
      `CHK(word, 16'h8123)
      $display("test serial done");
   endtask
   task automatic t_regs;
      av(1'b0, REG_CTRL, 32'h0);
      `CHK(r, 32'h0)
      av(1'b1, 4'hC, 32'hFFFF_FFFF);
      av(1'b0, 4'hC, 32'h0);
      `CHK(r, 32'h0)
      cyc(7'h41, 18'h00000, 16'h0000, 1'b0);
      av(1'b0, REG_REFCNT, 32'h0);
      `CHK(r[15:0], 16'h0000)
      av(1'b1, REG_CTRL, 32'h1);
      av(1'b0, REG_CTRL, 32'h0);
      `CHK(r, 32'h1)
      cyc(7'h41, 18'h00000, 16'h0000, 1'b0);
      cyc(7'h01, 18'h00000, 16'h0000, 1'b0);
      `CHK(ok, 1'b0)
      av(1'b0, REG_REFCNT, 32'h0);
      `CHK(r[15:0], 16'h0001)
      // Pass left unfinished past the retention window
      tick(200);
      av(1'b0, REG_STATUS, 32'h0);
      `CHK(r[21:16], 6'h01)
      `CHK(r[1], 1'b1)
      $display("test registers done");
   endtask
   initial begin
      clk_sys = 1'b0;
      reset_n = 1'b0;
      {avs_read, avs_write, card_sel, cycle_req, write_en, go} = 6'h00;
      {word_mode, clear_en, clear_value, split_en, refresh_req} = 5'h00;
      {avs_address, avs_writedata, addr, data_in, bit_in} = 71'h0;
      n_fail = 0;
      n_compared = 0;
      // Long hold so the link side sees several shift edges in reset
      tick(100);
      reset_n <= 1'b1;
      tick(1);
      t_word();
      t_bit();
      t_clear_split();
      t_serial();
      t_regs();
      report_and_stop();
   end
endmodule
`default_nettype wire
